// *** cdps_pkg.sv ***
// Constants and carrier types for the codec digital pin function select
// Operation
// - Multi-function pin code 0000 disables both its input and output buffers.
// - Code 0001 makes the multi-function pin an input routed to internal consumers.
// - Code 0010 makes the multi-function pin a general-purpose input read by software.
// - Code 0011 drives the multi-function pin with the register's lowest bit.
// - Codes 0100, 0101, 0110 drive clock output, interrupt one, interrupt two.
// - Codes 0111, 1000, 1001 drive record word clock, secondary bit and word clocks.
// - Code 1011 drives the secondary serial data output on the multi-function pin.
// - Multi-function register bit 1 is read-only and returns the input buffer level.
// - Multi-function register bit 0, reset 0, is the general-purpose output level.
// - Serial out bit 4, reset 1, disables the bus keeper when set.
// - Serial out code 000 powers the buffer down; code 001, reset, is primary data.
// - Serial out codes 010 and 011 drive general-purpose level and clock output.
// - Serial out codes 100 and 101 drive interrupt one and interrupt two.
// - Serial out codes 110 and 111 drive secondary bit clock and word clock.
// - Serial out bit 0, reset 0, is the general-purpose output level.
// - Serial in code 00 powers input down; code 01, reset, enables data input.
// - Serial in code 10 is general-purpose input; code 11 is reserved.
// - Serial in register bit 0 is read-only and returns the input buffer level.
// - Routed interrupts are active-high 2 ms pulses, single or repeated every 4 ms.
package cdps_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] MFP_CTRL_ADDR = 8'h33;
  localparam logic [7:0] RSVD_PIN_ADDR = 8'h34;
  localparam logic [7:0] SOP_CTRL_ADDR = 8'h35;
  localparam logic [7:0] SIP_CTRL_ADDR = 8'h36;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MFP_CTRL_RST = 8'h00;
  localparam logic [7:0] SOP_CTRL_RST = 8'h12;
  localparam logic [7:0] SIP_CTRL_RST = 8'h02;

  // ==========================================================
  // Multi-function pin function codes
  localparam logic [3:0] MFP_OFF = 4'h0;
  localparam logic [3:0] MFP_ROUTE_IN = 4'h1;
  localparam logic [3:0] MFP_GPI = 4'h2;
  localparam logic [3:0] MFP_GPO = 4'h3;
  localparam logic [3:0] MFP_CLK_OUT = 4'h4;
  localparam logic [3:0] MFP_INTERRUPT_LINE_ONE = 4'h5;
  localparam logic [3:0] MFP_INTERRUPT_LINE_TWO = 4'h6;
  localparam logic [3:0] MFP_REC_WCLK = 4'h7;
  localparam logic [3:0] MFP_SEC_BCLK = 4'h8;
  localparam logic [3:0] MFP_SEC_WCLK = 4'h9;
  localparam logic [3:0] MFP_MIC_CLK = 4'hA;
  localparam logic [3:0] MFP_SEC_DOUT = 4'hB;

  // ==========================================================
  // Serial out and serial in pin codes
  localparam logic [2:0] SOP_OFF = 3'h0;
  localparam logic [2:0] SOP_PRI_DOUT = 3'h1;
  localparam logic [2:0] SOP_GPO = 3'h2;
  localparam logic [2:0] SOP_CLK_OUT = 3'h3;
  localparam logic [2:0] SOP_INTERRUPT_LINE_ONE = 3'h4;
  localparam logic [2:0] SOP_INTERRUPT_LINE_TWO = 3'h5;
  localparam logic [2:0] SOP_SEC_BCLK = 3'h6;
  localparam logic [2:0] SOP_SEC_WCLK = 3'h7;
  localparam logic [1:0] SIP_OFF = 2'h0;
  localparam logic [1:0] SIP_DATA_IN = 2'h1;
  localparam logic [1:0] SIP_GPI = 2'h2;

  // ==========================================================
  // Interrupt pulse timing
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int INT_PULSE_TIME_US = 2000;
  localparam int INT_PERIOD_TIME_US = 4000;
  localparam int INT_PULSE_CYC = INT_PULSE_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int INT_PERIOD_CYC = INT_PERIOD_TIME_US * CLK_FREQ_KHZ / 1000;
  localparam int INT_CNT_W = 17;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic internal_clock_output;
    logic rec_wclk;
    logic sec_bclk;
    logic sec_wclk;
    logic mic_modulator_clock;
    logic sec_dout;
    logic pri_dout;
  } cdps_src_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [3:0] func;
    logic in_level;
    logic out_level;
  } cdps_mfp_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic keeper_dis;
    logic [2:0] func;
    logic out_level;
  } cdps_sop_t;

endpackage

// *** cdps_int_pulse.sv ***
// Interrupt line pulse shaper: single or repeated active-high pulses
`timescale 1ns/1ps
module cdps_int_pulse #(
  parameter int PULSE_CYC = cdps_pkg::INT_PULSE_CYC,
  parameter int PERIOD_CYC = cdps_pkg::INT_PERIOD_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic event_in,
  input wire logic repeat_in,
  input wire logic flag_read_in,
  output logic pulse_out
);

  // ==========================================================
  // State and counter
  typedef enum logic [1:0] {
    CDPS_IDLE = 2'b00,
    CDPS_HIGH = 2'b01,
    CDPS_LOW = 2'b11
  } cdps_pstate_t;

  localparam logic [cdps_pkg::INT_CNT_W-1:0] HIGH_LAST =
    cdps_pkg::INT_CNT_W'(PULSE_CYC - 1);
  localparam logic [cdps_pkg::INT_CNT_W-1:0] LOW_LAST =
    cdps_pkg::INT_CNT_W'(PERIOD_CYC - PULSE_CYC - 1);

  cdps_pstate_t state_q;
  logic [cdps_pkg::INT_CNT_W-1:0] cnt_q;
  logic stop_q;

  // Event restarts the pulse even on a flag read cycle, so no event is lost
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= CDPS_IDLE;
      cnt_q <= '0;
      stop_q <= 1'b0;
    end else if (event_in) begin
      state_q <= CDPS_HIGH;
      cnt_q <= '0;
      stop_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      if (flag_read_in) begin
        stop_q <= 1'b1;
      end
      case (state_q)
        CDPS_HIGH: begin
          if (cnt_q == HIGH_LAST) begin
            cnt_q <= '0;
            // Flag read mid-pulse lets the pulse finish at full width
            state_q <= (repeat_in && !stop_q && !flag_read_in) ? CDPS_LOW : CDPS_IDLE;
          end
        end
        CDPS_LOW: begin
          if (flag_read_in) begin
            state_q <= CDPS_IDLE;
          end else if (cnt_q == LOW_LAST) begin
            cnt_q <= '0;
            state_q <= CDPS_HIGH;
          end
        end
        default: begin
          cnt_q <= '0;
          state_q <= CDPS_IDLE;
        end
      endcase
    end
  end

  assign pulse_out = (state_q == CDPS_HIGH);

  // ==========================================================
  // Checks
  pulse_width_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CDPS_HIGH) |-> (cnt_q <= HIGH_LAST))
    else $error("interrupt pulse longer than its width");
  pulse_end_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CDPS_HIGH && cnt_q == HIGH_LAST && !event_in && !repeat_in)
      |=> !pulse_out)
    else $error("single interrupt pulse did not end");
  pulse_gap_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CDPS_LOW) |-> (cnt_q <= LOW_LAST))
    else $error("interrupt gap longer than its period");

endmodule

// *** cdps_top.sv ***
// Function select and value logic for the three multi-purpose digital pins
`timescale 1ns/1ps
module cdps_top #(
  parameter int INT_PULSE_CYC = cdps_pkg::INT_PULSE_CYC,
  parameter int INT_PERIOD_CYC = cdps_pkg::INT_PERIOD_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire cdps_pkg::cdps_src_t SRC_IN,
  input wire logic INTERRUPT_LINE_ONE_EVENT_IN,
  input wire logic INTERRUPT_LINE_TWO_EVENT_IN,
  input wire logic INTERRUPT_LINE_ONE_REPEAT_IN,
  input wire logic INTERRUPT_LINE_TWO_REPEAT_IN,
  input wire logic FLAG_READ_IN,
  input wire logic MFP_IN,
  output logic MFP_OUT,
  output logic MFP_OE_OUT,
  output logic MFP_ROUTE_OUT,
  output logic SOP_OUT,
  output logic SOP_OE_OUT,
  output logic SOP_KEEPER_EN_OUT,
  input wire logic SIP_IN,
  output logic SIP_ROUTE_OUT,
  output logic SIP_GPI_OUT
);

  // ==========================================================
  // Control registers
  cdps_pkg::cdps_mfp_t mfp_q;
  cdps_pkg::cdps_sop_t sop_q;
  logic [7:1] sip_q;
  logic interrupt_line_one_pulse;
  logic interrupt_line_two_pulse;
  logic mfp_in_buf;
  logic sip_in_buf;
  logic mfp_out_d;
  logic mfp_oe_d;
  logic sop_out_d;
  logic sop_oe_d;
  logic [7:0] rdata_d;
  logic [1:0] sip_func;

  assign sip_func = sip_q[2:1];

  // Register writes; the reserved slot ignores writes
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mfp_q <= cdps_pkg::MFP_CTRL_RST;
      sop_q <= cdps_pkg::SOP_CTRL_RST;
      sip_q <= cdps_pkg::SIP_CTRL_RST[7:1];
    end else if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        cdps_pkg::MFP_CTRL_ADDR: begin
          mfp_q.rsvd <= REG_WDATA_IN[7:6];
          mfp_q.func <= REG_WDATA_IN[5:2];
          // Bit 1 never stored; reads return the live input level instead
          mfp_q.out_level <= REG_WDATA_IN[0];
        end
        cdps_pkg::SOP_CTRL_ADDR: begin
          sop_q <= REG_WDATA_IN;
        end
        cdps_pkg::SIP_CTRL_ADDR: begin
          sip_q <= REG_WDATA_IN[7:1];
        end
        default: begin
          mfp_q <= mfp_q;
        end
      endcase
    end
  end

  // ==========================================================
  // Input buffers: a powered-down buffer senses nothing
  always_comb begin
    mfp_in_buf = (mfp_q.func != cdps_pkg::MFP_OFF) && MFP_IN;
    sip_in_buf = (sip_func != cdps_pkg::SIP_OFF) && SIP_IN;
  end

  // ==========================================================
  // Interrupt pulse shapers
  cdps_int_pulse #(
    .PULSE_CYC(INT_PULSE_CYC),
    .PERIOD_CYC(INT_PERIOD_CYC)
  ) u_interrupt_line_one (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .event_in(INTERRUPT_LINE_ONE_EVENT_IN),
    .repeat_in(INTERRUPT_LINE_ONE_REPEAT_IN),
    .flag_read_in(FLAG_READ_IN),
    .pulse_out(interrupt_line_one_pulse)
  );

  cdps_int_pulse #(
    .PULSE_CYC(INT_PULSE_CYC),
    .PERIOD_CYC(INT_PERIOD_CYC)
  ) u_interrupt_line_two (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .event_in(INTERRUPT_LINE_TWO_EVENT_IN),
    .repeat_in(INTERRUPT_LINE_TWO_REPEAT_IN),
    .flag_read_in(FLAG_READ_IN),
    .pulse_out(interrupt_line_two_pulse)
  );

  // ==========================================================
  // Multi-function pin output select
  always_comb begin
    mfp_oe_d = 1'b1;
    mfp_out_d = 1'b0;
    case (mfp_q.func)
      cdps_pkg::MFP_GPO: mfp_out_d = mfp_q.out_level;
      cdps_pkg::MFP_CLK_OUT: mfp_out_d = SRC_IN.internal_clock_output;
      cdps_pkg::MFP_INTERRUPT_LINE_ONE: mfp_out_d = interrupt_line_one_pulse;
      cdps_pkg::MFP_INTERRUPT_LINE_TWO: mfp_out_d = interrupt_line_two_pulse;
      cdps_pkg::MFP_REC_WCLK: mfp_out_d = SRC_IN.rec_wclk;
      cdps_pkg::MFP_SEC_BCLK: mfp_out_d = SRC_IN.sec_bclk;
      cdps_pkg::MFP_SEC_WCLK: mfp_out_d = SRC_IN.sec_wclk;
      cdps_pkg::MFP_MIC_CLK: mfp_out_d = SRC_IN.mic_modulator_clock;
      cdps_pkg::MFP_SEC_DOUT: mfp_out_d = SRC_IN.sec_dout;
      // Off, input modes and reserved codes leave the pin undriven
      default: mfp_oe_d = 1'b0;
    endcase
  end

  // ==========================================================
  // Serial out pin output select
  always_comb begin
    sop_oe_d = 1'b1;
    sop_out_d = 1'b0;
    case (sop_q.func)
      cdps_pkg::SOP_PRI_DOUT: sop_out_d = SRC_IN.pri_dout;
      cdps_pkg::SOP_GPO: sop_out_d = sop_q.out_level;
      cdps_pkg::SOP_CLK_OUT: sop_out_d = SRC_IN.internal_clock_output;
      cdps_pkg::SOP_INTERRUPT_LINE_ONE: sop_out_d = interrupt_line_one_pulse;
      cdps_pkg::SOP_INTERRUPT_LINE_TWO: sop_out_d = interrupt_line_two_pulse;
      cdps_pkg::SOP_SEC_BCLK: sop_out_d = SRC_IN.sec_bclk;
      cdps_pkg::SOP_SEC_WCLK: sop_out_d = SRC_IN.sec_wclk;
      default: sop_oe_d = 1'b0;
    endcase
  end

  // ==========================================================
  // Registered pin drivers, one cycle behind the select
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      MFP_OUT <= 1'b0;
      MFP_OE_OUT <= 1'b0;
      SOP_OUT <= 1'b0;
      SOP_OE_OUT <= 1'b0;
      SOP_KEEPER_EN_OUT <= 1'b0;
    end else begin
      MFP_OUT <= mfp_out_d;
      MFP_OE_OUT <= mfp_oe_d;
      SOP_OUT <= sop_out_d;
      SOP_OE_OUT <= sop_oe_d;
      SOP_KEEPER_EN_OUT <= !sop_q.keeper_dis;
    end
  end

  // ==========================================================
  // Routed inputs toward the audio interface and clock generator
  // Gated to zero so a consumer never sees a pin in another role
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      MFP_ROUTE_OUT <= 1'b0;
      SIP_ROUTE_OUT <= 1'b0;
      SIP_GPI_OUT <= 1'b0;
    end else begin
      MFP_ROUTE_OUT <= (mfp_q.func == cdps_pkg::MFP_ROUTE_IN) && mfp_in_buf;
      SIP_ROUTE_OUT <= (sip_func == cdps_pkg::SIP_DATA_IN) && sip_in_buf;
      SIP_GPI_OUT <= (sip_func == cdps_pkg::SIP_GPI) && sip_in_buf;
    end
  end

  // ==========================================================
  // Read data; reserved slot and unmapped offsets read zero
  always_comb begin
    case (REG_ADDR_IN)
      cdps_pkg::MFP_CTRL_ADDR:
        rdata_d = {mfp_q.rsvd, mfp_q.func, mfp_in_buf, mfp_q.out_level};
      cdps_pkg::SOP_CTRL_ADDR: rdata_d = sop_q;
      cdps_pkg::SIP_CTRL_ADDR: rdata_d = {sip_q, sip_in_buf};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= rdata_d;
    end
  end

  // ==========================================================
  // Checks
  mfp_off_quiet_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (mfp_q.func == cdps_pkg::MFP_OFF) |=> !MFP_OE_OUT)
    else $error("disabled multi-function pin is driven");
  mfp_route_in_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (mfp_q.func == cdps_pkg::MFP_ROUTE_IN) |=> (!MFP_OE_OUT && MFP_ROUTE_OUT == $past(MFP_IN)))
    else $error("routed input does not follow the pin");
  mfp_gpo_level_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (mfp_q.func == cdps_pkg::MFP_GPO) |=> (MFP_OE_OUT && MFP_OUT == $past(mfp_q.out_level)))
    else $error("multi-function output level wrong");
  mfp_int_line_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (mfp_q.func == cdps_pkg::MFP_INTERRUPT_LINE_TWO) |=> (MFP_OUT == $past(interrupt_line_two_pulse)))
    else $error("interrupt two not on multi-function pin");
  mfp_mic_clk_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (mfp_q.func == cdps_pkg::MFP_MIC_CLK) |=>
      (MFP_OE_OUT && MFP_OUT == $past(SRC_IN.mic_modulator_clock)))
    else $error("mic modulator clock not on multi-function pin");
  mfp_sec_dout_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (mfp_q.func == cdps_pkg::MFP_SEC_DOUT) |=> (MFP_OUT == $past(SRC_IN.sec_dout)))
    else $error("secondary data not on multi-function pin");
  mfp_read_in_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (REG_RD_IN && REG_ADDR_IN == cdps_pkg::MFP_CTRL_ADDR && mfp_q.func != cdps_pkg::MFP_OFF)
      |=> (REG_RDATA_OUT[1] == $past(MFP_IN)))
    else $error("multi-function input level not read back");
  sop_off_quiet_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (sop_q.func == cdps_pkg::SOP_OFF) |=> !SOP_OE_OUT)
    else $error("disabled serial out pin is driven");
  sop_gpo_level_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (sop_q.func == cdps_pkg::SOP_GPO) |=> (SOP_OE_OUT && SOP_OUT == $past(sop_q.out_level)))
    else $error("serial out level wrong");
  sop_int_line_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (sop_q.func == cdps_pkg::SOP_INTERRUPT_LINE_ONE) |=> (SOP_OUT == $past(interrupt_line_one_pulse)))
    else $error("interrupt one not on serial out pin");
  sop_keeper_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ##1 (SOP_KEEPER_EN_OUT == !$past(sop_q.keeper_dis)))
    else $error("bus keeper enable wrong");
  sip_read_in_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (REG_RD_IN && REG_ADDR_IN == cdps_pkg::SIP_CTRL_ADDR) |=>
      (REG_RDATA_OUT[0] == ($past(SIP_IN) && $past(sip_func) != cdps_pkg::SIP_OFF)))
    else $error("serial in level not read back");
  sip_gpi_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (sip_func == cdps_pkg::SIP_GPI) |=> (!SIP_ROUTE_OUT && SIP_GPI_OUT == $past(SIP_IN)))
    else $error("serial in general-purpose input wrong");

endmodule

// *** cdps_pin_partner.sv ***
// Far-side pin model: host or audio logic facing the digital pins
`timescale 1ns/1ps
module cdps_pin_partner (
  input wire logic clk_in,
  input wire logic mfp_out_in,
  input wire logic mfp_oe_in,
  input wire logic mfp_drive_in,
  input wire logic mfp_level_in,
  input wire logic sip_drive_in,
  input wire logic sip_level_in,
  output logic mfp_pin_out,
  output logic sip_pin_out
);
  // ==========================================================
  // Floating wire stand-in
  logic float_q = 1'b0;

  // Toggles each cycle so an undriven pin never looks like a steady level
  always_ff @(posedge clk_in) begin
    float_q <= ~float_q;
  end

  // ==========================================================
  // Wire resolution
  // Host backs off whenever the device enables its output buffer
  assign mfp_pin_out = mfp_oe_in ? mfp_out_in : (mfp_drive_in ? mfp_level_in : float_q);
  assign sip_pin_out = sip_drive_in ? sip_level_in : float_q;
endmodule

// *** cdps_tb_top.sv ***
// Self-checking testbench for the digital pin function select block
`timescale 1ns/1ps
module cdps_tb_top;
  // ==========================================================
  // Stimulus and observation signals
  localparam int PULSE = 4;
  localparam int PERIOD = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  cdps_pkg::cdps_src_t src = 7'h01;
  logic interrupt_line_one_ev = 1'b0;
  logic interrupt_line_two_ev = 1'b0;
  logic interrupt_line_one_rep = 1'b0;
  logic interrupt_line_two_rep = 1'b0;
  logic flag_rd = 1'b0;
  logic mfp_lvl = 1'b1;
  logic sip_lvl = 1'b1;
  logic mfp_pin, mfp_out, mfp_oe, mfp_route, sop_out, sop_oe, sop_keep;
  logic sip_pin, sip_route, sip_gpi;
  int n_mismatch = 0;
  int n_compared = 0;

  always #25 clk = ~clk;

  cdps_top #(.INT_PULSE_CYC(PULSE), .INT_PERIOD_CYC(PERIOD)) dut_u (
    .CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(reg_addr), .REG_WR_IN(reg_wr),
    .REG_WDATA_IN(reg_wdata), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata),
    .SRC_IN(src), .INTERRUPT_LINE_ONE_EVENT_IN(interrupt_line_one_ev), .INTERRUPT_LINE_TWO_EVENT_IN(interrupt_line_two_ev),
    .INTERRUPT_LINE_ONE_REPEAT_IN(interrupt_line_one_rep), .INTERRUPT_LINE_TWO_REPEAT_IN(interrupt_line_two_rep), .FLAG_READ_IN(flag_rd),
    .MFP_IN(mfp_pin), .MFP_OUT(mfp_out), .MFP_OE_OUT(mfp_oe), .MFP_ROUTE_OUT(mfp_route),
    .SOP_OUT(sop_out), .SOP_OE_OUT(sop_oe), .SOP_KEEPER_EN_OUT(sop_keep),
    .SIP_IN(sip_pin), .SIP_ROUTE_OUT(sip_route), .SIP_GPI_OUT(sip_gpi));

  cdps_pin_partner partner_u (
    .clk_in(clk), .mfp_out_in(mfp_out), .mfp_oe_in(mfp_oe), .mfp_drive_in(1'b1),
    .mfp_level_in(mfp_lvl), .sip_drive_in(1'b1), .sip_level_in(sip_lvl),
    .mfp_pin_out(mfp_pin), .sip_pin_out(sip_pin));

  // ==========================================================
  // Compare and report tasks
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: value got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Register access over the strobe port
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is loaded at the strobe edge, so look just after it
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_byte(reg_rdata, exp);
  endtask

  // Register update plus one registered pin stage, with margin
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // High cycles on both serial and multi-function pins over 16 cycles
  task automatic count_high(output logic [7:0] n_mfp, output logic [7:0] n_sop);
    n_mfp = 8'h00;
    n_sop = 8'h00;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #1;
      n_mfp = n_mfp + {7'h00, mfp_out};
      n_sop = n_sop + {7'h00, sop_out};
    end
  endtask

  // Source bit that each driving function code must route
  function automatic logic [6:0] src_mask(input logic is_sop, input int c);
    case (c)
      1: return is_sop ? 7'h01 : 7'h00;
      3: return is_sop ? 7'h40 : 7'h00;
      4: return is_sop ? 7'h00 : 7'h40;
      6: return is_sop ? 7'h10 : 7'h00;
      7: return is_sop ? 7'h08 : 7'h20;
      8: return is_sop ? 7'h00 : 7'h10;
      9: return is_sop ? 7'h00 : 7'h08;
      10: return is_sop ? 7'h00 : 7'h04;
      11: return is_sop ? 7'h00 : 7'h02;
      default: return 7'h00;
    endcase
  endfunction

  // ==========================================================
  // Hang guard
  initial begin
    #(20000 * 50);
    n_mismatch++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [6:0] m;
    logic oe_x;
    logic out_x;
    logic rb_x;
    logic [7:0] n1;
    logic [7:0] n2;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk_bit(sop_oe, 1'b1, "serial out enable");
    chk_bit(sop_out, 1'b1, "serial out data");
    chk_bit(sop_keep, 1'b0, "keeper enable");
    chk_bit(mfp_oe, 1'b0, "multi pin enable");
    rd_chk(cdps_pkg::MFP_CTRL_ADDR, 8'h00);
    rd_chk(cdps_pkg::SOP_CTRL_ADDR, 8'h12);
    rd_chk(cdps_pkg::SIP_CTRL_ADDR, 8'h03);
    rd_chk(cdps_pkg::RSVD_PIN_ADDR, 8'h00);
    rd_chk(8'h40, 8'h00);
    // Multi-function pin: each defined code, both levels; top bits stay 00
    for (int c = 0; c < 12; c++) begin
      for (int p = 0; p < 2; p++) begin
        m = src_mask(1'b0, c);
        @(posedge clk);
        src <= cdps_pkg::cdps_src_t'(p[0] ? m : ~m);
        mfp_lvl <= p[0];
        wr_reg(cdps_pkg::MFP_CTRL_ADDR, {2'b00, c[3:0], 1'b1, p[0]});
        settle();
        oe_x = (c > 2);
        out_x = (c == 5 || c == 6) ? 1'b0 : p[0];
        rb_x = (c == 0) ? 1'b0 : (oe_x ? out_x : p[0]);
        chk_bit(mfp_oe, oe_x, "multi pin enable");
        if (oe_x) begin
          chk_bit(mfp_out, out_x, "multi pin data");
        end
        chk_bit(mfp_route, (c == 1) & p[0], "multi pin route");
        rd_chk(cdps_pkg::MFP_CTRL_ADDR, {2'b00, c[3:0], rb_x, p[0]});
      end
    end
    // Serial out pin: every code, keeper bit and level toggled together
    for (int c = 0; c < 8; c++) begin
      for (int p = 0; p < 2; p++) begin
        m = src_mask(1'b1, c);
        @(posedge clk);
        src <= cdps_pkg::cdps_src_t'(p[0] ? m : ~m);
        wr_reg(cdps_pkg::SOP_CTRL_ADDR, {3'b000, p[0], c[2:0], p[0]});
        settle();
        chk_bit(sop_oe, c != 0, "serial out enable");
        if (c != 0) begin
          chk_bit(sop_out, (c == 4 || c == 5) ? 1'b0 : p[0], "serial out data");
        end
        chk_bit(sop_keep, ~p[0], "keeper enable");
        rd_chk(cdps_pkg::SOP_CTRL_ADDR, {3'b000, p[0], c[2:0], p[0]});
      end
    end
    // Serial in pin: defined codes only, read-only bit written opposite
    for (int c = 0; c < 3; c++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        sip_lvl <= p[0];
        wr_reg(cdps_pkg::SIP_CTRL_ADDR, {5'b00000, c[1:0], ~p[0]});
        settle();
        chk_bit(sip_route, (c == 1) & p[0], "serial in route");
        chk_bit(sip_gpi, (c == 2) & p[0], "serial in gpi");
        rd_chk(cdps_pkg::SIP_CTRL_ADDR, {5'b00000, c[1:0], (c != 0) & p[0]});
      end
    end
    // Interrupts: line two single pulse, line one repeating until flag read
    wr_reg(cdps_pkg::MFP_CTRL_ADDR, 8'h18);
    wr_reg(cdps_pkg::SOP_CTRL_ADDR, 8'h08);
    @(posedge clk);
    interrupt_line_one_rep <= 1'b1;
    settle();
    @(posedge clk);
    interrupt_line_one_ev <= 1'b1;
    interrupt_line_two_ev <= 1'b1;
    @(posedge clk);
    interrupt_line_one_ev <= 1'b0;
    interrupt_line_two_ev <= 1'b0;
    count_high(n1, n2);
    chk_byte(n1, 8'(PULSE));
    chk_byte(n2, 8'(2 * PULSE));
    @(posedge clk);
    flag_rd <= 1'b1;
    @(posedge clk);
    flag_rd <= 1'b0;
    repeat (PERIOD + 4) @(posedge clk);
    count_high(n1, n2);
    chk_byte(n2, 8'h00);
    // Flag read in the low gap stops the repeat at once
    @(posedge clk);
    interrupt_line_one_ev <= 1'b1;
    @(posedge clk);
    interrupt_line_one_ev <= 1'b0;
    repeat (5) @(posedge clk);
    flag_rd <= 1'b1;
    @(posedge clk);
    flag_rd <= 1'b0;
    count_high(n1, n2);
    chk_byte(n2, 8'h00);
    end_sim();
  end
endmodule
